// *** hw/lsl_pkg.sv ***
package lsl_pkg;
  // ==========================================================
  // sizes
  localparam int unsigned LSL_CH_N    = 16;
  localparam int unsigned LSL_GAIN_W  = 8;
  localparam int unsigned LSL_EV_W    = 4;
  localparam int unsigned LSL_AW      = 8;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] LSL_OFF_STATUS = 8'h00;
  localparam logic [7:0] LSL_OFF_MASK   = 8'h04;
  localparam logic [7:0] LSL_OFF_STATE  = 8'h08;
  localparam logic [7:0] LSL_OFF_GAIN   = 8'h0c;
  localparam logic [7:0] LSL_OFF_ERROR  = 8'h10;
  localparam logic [7:0] LSL_OFF_LATCH  = 8'h14;
  localparam logic [7:0] LSL_OFF_CTRL   = 8'h18;
  // ==========================================================
  // field positions
  localparam int unsigned LSL_EV_SPECIAL = 0;
  localparam int unsigned LSL_EV_NORMAL  = 1;
  localparam int unsigned LSL_EV_FAULT   = 2;
  localparam int unsigned LSL_EV_LATCH   = 3;
  localparam int unsigned LSL_CTRL_BLANK = 0;
  localparam int unsigned LSL_HTRANS_ACT = 1;
  // ==========================================================
  // reset values
  localparam logic [7:0]  LSL_GAIN_RST  = 8'hff;
  localparam logic [3:0]  LSL_MASK_RST  = 4'h0;
  localparam logic [15:0] LSL_LATCH_RST = 16'h0000;
  // ==========================================================
  // types
  typedef enum logic [1:0] {LSL_NORMAL, LSL_SWITCH, LSL_SPECIAL} lsl_phase_e;
  typedef struct packed {
    logic [15:0] open_load;
    logic [15:0] short_gnd;
    logic [15:0] short_supply;
    logic        over_temp;
  } lsl_fault_s;
  typedef struct packed {
    logic serial_clk;
    logic serial_in;
    logic latch_strobe;
    logic latch_strobe_undriven;
    logic output_blank_n;
  } lsl_pins_s;
  function automatic logic lsl_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction
endpackage

// *** hw/lsl_ctrl.sv ***
// Contract
// - each serial clock rise, except one that loads error bits, shifts serial_in into the shift register
// - 16-bit shift register plus parallel output latch, one bit per channel
// - last shift-register bit drives serial_out
// - strobe high passes shift register to latch; falling strobe holds it
// - blank low drives outputs from latch unless the CTRL blank bit is set; blank high turns all off
// - one-clock low pulse on blank starts the mode-switching phase
// - strobe level during switching selects normal or special mode
// - special mode: blank low enables outputs and checks channel current
// - special mode loads error bits into shift register for shifting out
// - special mode strobe loads 8-bit gain latch, output latch untouched
// - gain code applied as 256-step global current gain
// - one error bit per channel, flags any fault on it, open load only while that channel's latch bit is set
// - open-load, short-to-ground, optional supply short, overtemperature
// - undriven strobe reads low so latches hold
// - return to normal mode clears all error bits
`timescale 1ns/10ps
module lsl_ctrl #(
  parameter bit HAS_SUPPLY_SHORT = 1'b1
) (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                hsel_in,
  input  wire logic [31:0]         haddr_in,
  input  wire logic [1:0]          htrans_in,
  input  wire logic                hwrite_in,
  input  wire logic [2:0]          hsize_in,
  input  wire logic [31:0]         hwdata_in,
  input  wire logic                hready_in,
  output logic                     hreadyout_out,
  output logic                     hresp_out,
  output logic [31:0]              hrdata_out,
  input  wire lsl_pkg::lsl_pins_s  pins_in,
  input  wire lsl_pkg::lsl_fault_s faults_in,
  output logic                     serial_out_out,
  output logic [15:0]              sink_outputs_out,
  output logic [7:0]               gain_code_out,
  output logic                     irq_out
);
  import lsl_pkg::*;

  localparam int unsigned SYNC_W = $bits(lsl_pins_s) + $bits(lsl_fault_s);

  // ==========================================================
  // input synchronisers
  logic [SYNC_W-1:0] sync1_r;
  logic [SYNC_W-1:0] sync2_r;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {pins_in, faults_in};
      sync2_r <= sync1_r;
    end
  end

  lsl_pins_s  pins_s;
  lsl_fault_s flt_s;
  assign {pins_s, flt_s} = sync2_r;

  wire strobe_s = pins_s.latch_strobe & ~pins_s.latch_strobe_undriven;
  wire blank_s  = pins_s.output_blank_n;

  // ==========================================================
  // serial clock edge and blank history
  logic       sclk_prev_r;
  logic [1:0] blank_hist_r;
  wire        sclk_rise;
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_prev_r  <= 1'b0;
      blank_hist_r <= 2'b11;
    end else begin
      sclk_prev_r <= pins_s.serial_clk;
      if (sclk_rise)
        blank_hist_r <= {blank_hist_r[0], blank_s};
    end
  end

  assign sclk_rise  = pins_s.serial_clk & ~sclk_prev_r;
  // high, one sampled low, high again
  wire pulse_seen = sclk_rise & ({blank_hist_r, blank_s} == 3'b101);

  // ==========================================================
  // mode phase
  lsl_phase_e phase_r;
  lsl_phase_e phase_nxt;
  always_comb begin
    phase_nxt = phase_r;
    case (phase_r)
      LSL_NORMAL, LSL_SPECIAL: begin
        if (pulse_seen)
          phase_nxt = LSL_SWITCH;
      end
      LSL_SWITCH: begin
        if (sclk_rise)
          phase_nxt = strobe_s ? LSL_SPECIAL : LSL_NORMAL;
      end
      default: phase_nxt = LSL_NORMAL;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in)
      phase_r <= LSL_NORMAL;
    else
      phase_r <= phase_nxt;
  end

  wire in_special = (phase_r == LSL_SPECIAL);
  wire in_normal  = (phase_r == LSL_NORMAL);
  wire to_special = (phase_r == LSL_SWITCH) & sclk_rise & strobe_s;
  wire to_normal  = (phase_r == LSL_SWITCH) & sclk_rise & ~strobe_s;

  // ==========================================================
  // shift register, latches, outputs
  logic [15:0] shreg_r;
  logic [15:0] latch_r;
  logic [7:0]  gain_r;
  logic [15:0] err_r;
  logic [15:0] sink_r;
  logic        ctrl_blank_r;

  // error window closes when blank rises in special mode
  wire load_err  = in_special & sclk_rise & ~blank_hist_r[0] & blank_s;
  wire latch_en  = strobe_s & in_normal;
  wire gain_en   = strobe_s & in_special;
  wire drive_on  = ~blank_s & ~ctrl_blank_r;
  wire detect_en = in_special & ~blank_s;

  wire [15:0] supply_flt = HAS_SUPPLY_SHORT ? flt_s.short_supply : 16'h0000;
  // open load only visible on a channel whose latch bit is set
  wire [15:0] ch_fault = (flt_s.open_load & latch_r) | flt_s.short_gnd
                       | supply_flt | {16{flt_s.over_temp}};
  wire [15:0] err_nxt  = to_normal ? 16'h0000 :
                         detect_en ? (err_r | ch_fault) : err_r;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      shreg_r <= 16'h0000;
      latch_r <= LSL_LATCH_RST;
      gain_r  <= LSL_GAIN_RST;
      err_r   <= 16'h0000;
      sink_r  <= 16'h0000;
    end else begin
      if (load_err)
        shreg_r <= err_r;
      else if (sclk_rise)
        shreg_r <= {shreg_r[14:0], pins_s.serial_in};
      if (latch_en)
        latch_r <= shreg_r;
      if (gain_en)
        gain_r <= shreg_r[7:0];
      err_r  <= err_nxt;
      sink_r <= drive_on ? latch_r : 16'h0000;
    end
  end

  assign serial_out_out   = shreg_r[15];
  assign sink_outputs_out = sink_r;
  // code feeds the current regulator reference
  assign gain_code_out    = gain_r;

  // ==========================================================
  // events, status, interrupt
  logic [3:0] status_r;
  logic [3:0] mask_r;
  logic       irq_r;
  wire  [3:0] events;
  assign events[LSL_EV_SPECIAL] = to_special;
  assign events[LSL_EV_NORMAL]  = to_normal;
  assign events[LSL_EV_FAULT]   = detect_en & |(ch_fault & ~err_r);
  assign events[LSL_EV_LATCH]   = latch_en & (latch_r != shreg_r);

  // ==========================================================
  // ahb-lite slave, zero wait state
  logic       wr_pend_r;
  logic [7:0] wr_addr_r;
  logic [31:0] rdata_r;

  wire [7:0] a_addr   = haddr_in[LSL_AW-1:0];
  wire       a_phase  = hsel_in & hready_in & htrans_in[LSL_HTRANS_ACT];
  wire       wr_stat  = wr_pend_r & lsl_hit(wr_addr_r, LSL_OFF_STATUS);
  wire       wr_mask  = wr_pend_r & lsl_hit(wr_addr_r, LSL_OFF_MASK);
  wire       wr_ctrl  = wr_pend_r & lsl_hit(wr_addr_r, LSL_OFF_CTRL);
  wire [3:0] w1c      = wr_stat ? hwdata_in[3:0] : 4'h0;
  // set wins over a clear in the same cycle
  wire [3:0] status_nxt = (status_r & ~w1c) | events;

  wire [31:0] rd_mux =
    lsl_hit(a_addr, LSL_OFF_STATUS) ? {28'h0, status_r} :
    lsl_hit(a_addr, LSL_OFF_MASK)   ? {28'h0, mask_r} :
    lsl_hit(a_addr, LSL_OFF_STATE)  ? {29'h0, serial_out_out, phase_r} :
    lsl_hit(a_addr, LSL_OFF_GAIN)   ? {24'h0, gain_r} :
    lsl_hit(a_addr, LSL_OFF_ERROR)  ? {16'h0, err_r} :
    lsl_hit(a_addr, LSL_OFF_LATCH)  ? {16'h0, latch_r} :
    lsl_hit(a_addr, LSL_OFF_CTRL)   ? {31'h0, ctrl_blank_r} : 32'h0;

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      rdata_r   <= 32'h0;
    end else begin
      wr_pend_r <= a_phase & hwrite_in;
      if (a_phase)
        wr_addr_r <= a_addr;
      if (a_phase & ~hwrite_in)
        rdata_r <= rd_mux;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r     <= 4'h0;
      mask_r       <= LSL_MASK_RST;
      ctrl_blank_r <= 1'b0;
      irq_r        <= 1'b0;
    end else begin
      status_r <= status_nxt;
      if (wr_mask)
        mask_r <= hwdata_in[3:0];
      if (wr_ctrl)
        ctrl_blank_r <= hwdata_in[LSL_CTRL_BLANK];
      irq_r <= |(status_r & mask_r);
    end
  end

  assign hreadyout_out = 1'b1;
  assign hresp_out     = 1'b0;
  assign hrdata_out    = rdata_r;
  assign irq_out       = irq_r;

  // ==========================================================
  // checks
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  shift_step_a: assert property (sclk_rise && !load_err |=>
    shreg_r == {$past(shreg_r[14:0]), $past(pins_s.serial_in)})
    else $error("shift register did not take serial input");
  serial_tail_a: assert property (sclk_rise && !load_err |=>
    serial_out_out == $past(shreg_r[14]))
    else $error("serial output not last stage");
  latch_pass_a: assert property (latch_en |=> latch_r == $past(shreg_r))
    else $error("latch not transparent on strobe");
  latch_hold_a: assert property (!latch_en |=> $stable(latch_r))
    else $error("latch changed without strobe");
  blank_off_a: assert property (blank_s |=> sink_r == 16'h0000)
    else $error("outputs on while blanked");
  drive_on_a: assert property (drive_on |=> sink_r == $past(latch_r))
    else $error("outputs do not follow latch");
  pulse_switch_a: assert property (pulse_seen && phase_r != LSL_SWITCH
    |=> phase_r == LSL_SWITCH)
    else $error("blank pulse missed");
  mode_pick_a: assert property (phase_r == LSL_SWITCH && sclk_rise |=>
    phase_r == ($past(strobe_s) ? LSL_SPECIAL : LSL_NORMAL))
    else $error("wrong target mode");
  err_load_a: assert property (load_err |=> shreg_r == $past(err_r))
    else $error("error bits not loaded");
  gain_load_a: assert property (gain_en |=>
    gain_r == $past(shreg_r[7:0]) && $stable(latch_r))
    else $error("gain latch load wrong");
  err_sticky_a: assert property (detect_en |=>
    (err_r & $past(ch_fault)) == $past(ch_fault))
    else $error("fault not recorded");
  err_clear_a: assert property (to_normal |=> err_r == 16'h0000)
    else $error("errors kept after normal entry");
  strobe_pull_a: assert property (pins_s.latch_strobe_undriven
    |=> $stable(latch_r) && $stable(gain_r))
    else $error("undriven strobe loaded a latch");

  // holding behaviour between events
  force_blank_a: assert property (ctrl_blank_r |=> sink_r == 16'h0000)
    else $error("outputs on while forced blank");
  serial_hold_a: assert property (!sclk_rise |=> $stable(shreg_r))
    else $error("shift register moved without serial clock");
  strobe_low_a: assert property (!strobe_s |=>
    $stable(latch_r) && $stable(gain_r))
    else $error("latch loaded with strobe low");
  switch_quiet_a: assert property (phase_r == LSL_SWITCH |=>
    $stable(latch_r) && $stable(gain_r))
    else $error("latch loaded while switching");
  latch_special_a: assert property (in_special |=> $stable(latch_r))
    else $error("output latch changed in special mode");
  gain_hold_a: assert property (!gain_en |=> $stable(gain_r))
    else $error("gain changed without strobe");
  err_hold_a: assert property (!detect_en && !to_normal |=> $stable(err_r))
    else $error("error bits changed outside detection");
  err_normal_a: assert property (phase_r == LSL_NORMAL |-> err_r == 16'h0000)
    else $error("error bits set in normal mode");
  mode_stay_a: assert property (!pulse_seen && phase_r != LSL_SWITCH |=>
    phase_r == $past(phase_r))
    else $error("mode changed without blank pulse");

  enter_special_c: cover property (to_special);
  enter_normal_c:  cover property (to_normal);
  read_errors_c:   cover property (load_err ##[1:40] sclk_rise);
  fault_irq_c:     cover property (events[LSL_EV_FAULT] ##[1:3] irq_out);
  force_blank_c:   cover property (ctrl_blank_r && !blank_s);
endmodule // lsl_ctrl

// *** verif/lsl_ctrl_model.sv ***
`timescale 1ns/10ps
module lsl_ctrl_model (
  input  wire logic          clk_in,
  output lsl_pkg::lsl_pins_s pins_out
);
  import lsl_pkg::*;
  // ==========================================
  // controller side of the serial chain
  initial begin
    pins_out                = '0;
    pins_out.output_blank_n = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // serial clock stands low between bits; released data line flips
  task automatic send_bit(input logic d, input logic blank_n, input logic strobe);
    @(posedge clk_in);
    pins_out.serial_in      <= d;
    pins_out.output_blank_n <= blank_n;
    pins_out.latch_strobe   <= strobe;
    wait_clk(4);
    pins_out.serial_clk <= 1'b1;
    wait_clk(4);
    pins_out.serial_clk   <= 1'b0;
    pins_out.latch_strobe <= 1'b0;
    pins_out.serial_in    <= ~d;
    wait_clk(3);
  endtask
  task automatic send_word(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      send_bit(w[i], pins_out.output_blank_n, 1'b0);
    end
  endtask
  task automatic strobe_pulse(input logic undriven);
    @(posedge clk_in);
    pins_out.latch_strobe          <= 1'b1;
    pins_out.latch_strobe_undriven <= undriven;
    wait_clk(6);
    pins_out.latch_strobe          <= 1'b0;
    pins_out.latch_strobe_undriven <= 1'b0;
    wait_clk(4);
  endtask
  task automatic set_blank(input logic b);
    @(posedge clk_in);
    pins_out.output_blank_n <= b;
    wait_clk(4);
  endtask
  // one-period low blank pulse, then strobe level picks the mode
  task automatic switch_mode(input logic special);
    send_bit(1'b0, 1'b1, 1'b0);
    send_bit(1'b0, 1'b0, 1'b0);
    send_bit(1'b0, 1'b1, 1'b0);
    send_bit(1'b0, 1'b1, special);
  endtask
endmodule // lsl_ctrl_model

// *** verif/lsl_ctrl_tb.sv ***
`timescale 1ns/10ps
module lsl_ctrl_tb;
  import lsl_pkg::*;
  logic        clk_in, rst_n_in, hsel, hwrite, hreadyout, hresp, sout, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] sinks;
  logic [7:0]  gain;
  logic [23:0] addr_hi;
  lsl_pins_s   pins;
  lsl_fault_s  faults;
  int          fail_count, num_checks;

  lsl_ctrl_model i_lsl_ctrl_model (.clk_in(clk_in), .pins_out(pins));
  lsl_ctrl i_lsl_ctrl (
    .clk_in(clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
    .hready_in(hreadyout), .hreadyout_out(hreadyout), .hresp_out(hresp),
    .hrdata_out(hrdata), .pins_in(pins), .faults_in(faults), .serial_out_out(sout),
    .sink_outputs_out(sinks), .gain_code_out(gain), .irq_out(irq)
  );
  always #50 clk_in = ~clk_in;
  // ==========================================
  // bus and compare helpers
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk_in);
    hsel   <= 1'b1;
    haddr  <= {addr_hi, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk_in); while (hreadyout !== 1'b1);
    rd = hrdata;
    hsel <= 1'b0;
  endtask
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
    ahb(1'b0, a, 32'h00000000);
    check(rd & msk, exp, "register read");
  endtask
  task automatic test_done;
    if (fail_count == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset;
    check({sout, sinks, gain, hresp}, {1'b0, 16'h0000, LSL_GAIN_RST, 1'b0},
          "reset outputs");
    rd_chk(LSL_OFF_STATUS, 32'hffffffff, 32'h00000000);
    rd_chk(LSL_OFF_MASK, 32'hffffffff, 32'h00000000);
    rd_chk(LSL_OFF_LATCH, 32'hffffffff, 32'h00000000);
    rd_chk(8'h1c, 32'hffffffff, 32'h00000000);
    // upper address bits alias onto the same registers
    addr_hi = 24'h000001;
    rd_chk(LSL_OFF_GAIN, 32'hffffffff, {24'h000000, LSL_GAIN_RST});
    addr_hi = 24'h000000;
  endtask
  task automatic t_normal;
    i_lsl_ctrl_model.send_word(16'ha5c3);
    check(sout, 1'b1, "first bit out");
    check(sinks, 16'h0000, "blanked");
    i_lsl_ctrl_model.strobe_pulse(1'b0);
    rd_chk(LSL_OFF_LATCH, 32'hffffffff, 32'h0000a5c3);
    i_lsl_ctrl_model.set_blank(1'b0);
    check(sinks, 16'ha5c3, "enabled sinks");
    ahb(1'b1, LSL_OFF_CTRL, 32'h00000001);
    repeat (2) @(posedge clk_in);
    check(sinks, 16'h0000, "forced blank");
    ahb(1'b1, LSL_OFF_CTRL, 32'h00000000);
    repeat (2) @(posedge clk_in);
    check(sinks, 16'ha5c3, "force released");
    i_lsl_ctrl_model.send_word(16'h1234);
    i_lsl_ctrl_model.strobe_pulse(1'b1);
    check(sinks, 16'ha5c3, "floating strobe holds");
    i_lsl_ctrl_model.set_blank(1'b1);
    check(sinks, 16'h0000, "blank all off");
  endtask
  task automatic t_irq;
    rd_chk(LSL_OFF_STATUS, 32'hffffffff, 32'h00000008);
    ahb(1'b1, LSL_OFF_MASK, 32'h00000008);
    repeat (2) @(posedge clk_in);
    check(irq, 1'b1, "irq raised");
    ahb(1'b1, LSL_OFF_STATUS, 32'h00000008);
    repeat (2) @(posedge clk_in);
    check(irq, 1'b0, "irq cleared");
  endtask
  task automatic t_special;
    i_lsl_ctrl_model.switch_mode(1'b1);
    rd_chk(LSL_OFF_STATE, 32'h00000003, 32'h00000002);
    i_lsl_ctrl_model.send_word(16'h003c);
    i_lsl_ctrl_model.strobe_pulse(1'b0);
    check(gain, 8'h3c, "gain code");
    rd_chk(LSL_OFF_LATCH, 32'hffffffff, 32'h0000a5c3);
    faults.open_load[0]    <= 1'b1;
    faults.short_gnd[4]    <= 1'b1;
    faults.short_supply[9] <= 1'b1;
    repeat (2) i_lsl_ctrl_model.send_bit(1'b0, 1'b0, 1'b0);
    check(sinks, 16'ha5c3, "special outputs on");
    i_lsl_ctrl_model.send_bit(1'b0, 1'b1, 1'b0);
    faults <= '0;
    rd_chk(LSL_OFF_ERROR, 32'hffffffff, 32'h00000211);
    repeat (11) i_lsl_ctrl_model.send_bit(1'b0, 1'b1, 1'b0);
    check(sout, 1'b1, "error bit out");
    i_lsl_ctrl_model.switch_mode(1'b0);
    rd_chk(LSL_OFF_STATE, 32'h00000003, 32'h00000000);
    rd_chk(LSL_OFF_ERROR, 32'hffffffff, 32'h00000000);
    // second stint: overtemperature flags every channel
    i_lsl_ctrl_model.switch_mode(1'b1);
    faults.over_temp <= 1'b1;
    repeat (2) i_lsl_ctrl_model.send_bit(1'b0, 1'b0, 1'b0);
    i_lsl_ctrl_model.send_bit(1'b0, 1'b1, 1'b0);
    faults <= '0;
    rd_chk(LSL_OFF_ERROR, 32'hffffffff, 32'h0000ffff);
    i_lsl_ctrl_model.switch_mode(1'b0);
    rd_chk(LSL_OFF_ERROR, 32'hffffffff, 32'h00000000);
    rd_chk(LSL_OFF_STATUS, 32'hffffffff, 32'h00000007);
  endtask
  task automatic t_midreset;
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (3) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    rd_chk(LSL_OFF_STATE, 32'h00000007, 32'h00000000);
  endtask
  // ==========================================
  // run
  initial begin
    clk_in   = 1'b0;
    rst_n_in = 1'b0;
    {hsel, hwrite, htrans, hsize, haddr, hwdata} = '0;
    hsize    = 3'h2;
    faults   = '0;
    addr_hi  = 24'h000000;
    repeat (6) @(posedge clk_in);
    rst_n_in <= 1'b1;
    t_reset();
    t_normal();
    t_irq();
    t_special();
    t_midreset();
    test_done();
  end
  initial begin
    repeat (20000) @(posedge clk_in);
    fail_count++;
    test_done();
  end
endmodule // lsl_ctrl_tb
